// ### core/bst_tap_port.sv
// Boundary-scan access port with its controller, shift paths and output FIFO.
`timescale 1ns/1ns

module bst_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clock,     // System clock.
  input  wire logic             rst_n,     // Asynchronous reset, active low.
  input  wire logic             in_valid,  // Word offered.
  output logic                  in_ready,  // Space for a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word offered.
  output logic                  out_valid, // Head word present.
  input  wire logic             out_ready, // Head word taken.
  output logic [WIDTH-1:0]      out_data   // Head word.
);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               count;
    logic                        vld;
  } bst_fifo_st_t;

  bst_fifo_st_t r;
  bst_fifo_st_t next_r;

  assign in_ready  = (r.count != CW'(DEPTH));
  assign out_valid = r.vld;
  assign out_data  = r.mem[0];

  // Entry 0 is always the head, so the output word is a plain flip-flop.
  always_comb begin
    logic pop;
    logic push;
    pop    = r.vld && out_ready;
    push   = in_valid && in_ready;
    next_r = r;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_r.mem[i] = r.mem[i+1];
      end
      next_r.count = r.count - CW'(1);
    end
    if (push) begin
      next_r.mem[next_r.count] = in_data;
      next_r.count             = next_r.count + CW'(1);
    end
    next_r.vld = (next_r.count != '0);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule : bst_fifo

module bst_tap_port (
  input  wire logic                     clock,      // System clock, 50 MHz.
  input  wire logic                     nrst,       // System reset, active low.
  input  wire logic                     tck,        // Test clock pin.
  input  wire logic                     tms,        // Mode-select pin.
  input  wire logic                     tdi,        // Serial data in pin.
  input  wire logic                     trst_n,     // Test reset pin, active low.
  output logic                          tdo,        // Serial data out.
  output logic                          tdo_oe,     // Serial out enable, high drives.
  input  wire logic [bst_pkg::DR_W-1:0] cap_data,   // Word loaded at data capture.
  output logic                          out_valid,  // Shifted-in word ready.
  input  wire logic                     out_ready,  // User takes the word.
  output logic [bst_pkg::DR_W-1:0]      out_data,   // Shifted-in word.
  output logic                          drop_seen   // Word lost on a full FIFO.
);

  typedef struct packed {
    bst_pkg::bst_pins_t             s1;
    bst_pkg::bst_pins_t             s2;
    logic                           tck_d;
    bst_pkg::bst_tap_t              tap;
    logic [bst_pkg::IR_W-1:0]       ir;
    logic [bst_pkg::IR_W-1:0]       instr;
    logic [bst_pkg::DR_W-1:0]       dr;
    logic                           byp;
    logic                           tdo;
    logic                           tdo_oe;
    logic                           push;
    logic                           drop;
  } bst_top_st_t;

  bst_top_st_t r;
  bst_top_st_t next_r;
  logic        rst_n;
  logic        rise;
  logic        fall;
  logic        fifo_ready;
  logic        stream_sel;
  logic        shifting;

  // The test reset clears the whole port at once, without any clock edge.
  assign rst_n = nrst & trst_n;

  assign rise       = r.s2.tck && !r.tck_d;
  assign fall       = !r.s2.tck && r.tck_d;
  assign stream_sel = (r.instr == bst_pkg::INS_STREAM);
  assign shifting   = (r.tap == bst_pkg::ST_DR_SHIFT) || (r.tap == bst_pkg::ST_IR_SHIFT);

  assign tdo       = r.tdo;
  assign tdo_oe    = r.tdo_oe;
  assign drop_seen = r.drop;

  always_comb begin
    next_r       = r;
    next_r.s1    = '{tck: tck, tms: tms, tdi: tdi};
    next_r.s2    = r.s1;
    next_r.tck_d = r.s2.tck;
    next_r.push  = 1'b0;
    if (r.push && !fifo_ready) begin
      next_r.drop = 1'b1;
    end
    if (rise) begin
      next_r.tap = bst_pkg::bst_next(r.tap, r.s2.tms);
      unique case (r.tap)
        bst_pkg::ST_RESET: begin
          next_r.instr = bst_pkg::INS_RESET;
        end
        bst_pkg::ST_IR_CAP: begin
          next_r.ir = bst_pkg::IR_CAPTURE;
        end
        bst_pkg::ST_IR_SHIFT: begin
          next_r.ir = {r.s2.tdi, r.ir[bst_pkg::IR_W-1:1]};
        end
        bst_pkg::ST_IR_UPD: begin
          next_r.instr = r.ir;
        end
        bst_pkg::ST_DR_CAP: begin
          next_r.dr  = cap_data;
          next_r.byp = 1'b0;
        end
        bst_pkg::ST_DR_SHIFT: begin
          if (stream_sel) begin
            next_r.dr = {r.s2.tdi, r.dr[bst_pkg::DR_W-1:1]};
          end else begin
            next_r.byp = r.s2.tdi;
          end
        end
        bst_pkg::ST_DR_UPD: begin
          next_r.push = stream_sel;
        end
        default: begin
        end
      endcase
    end
    if (fall) begin
      next_r.tdo_oe = shifting;
      if (r.tap == bst_pkg::ST_IR_SHIFT) begin
        next_r.tdo = r.ir[0];
      end else if (r.tap == bst_pkg::ST_DR_SHIFT) begin
        next_r.tdo = stream_sel ? r.dr[0] : r.byp;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r       <= '0;
      r.tap   <= bst_pkg::ST_RESET;
      r.instr <= bst_pkg::INS_RESET;
    end else begin
      r <= next_r;
    end
  end

  bst_fifo #(
    .WIDTH (bst_pkg::DR_W),
    .DEPTH (bst_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (r.push),
    .in_ready  (fifo_ready),
    .in_data   (r.dr),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_still_without_edge;
    !rise |=> $stable(r.tap) && $stable(r.ir) && $stable(r.dr);
  endproperty
  a_still_without_edge: assert property (p_still_without_edge)
    else $error("Scan state moved without a test-clock rise.");

  property p_ir_shift_in;
    rise && r.tap == bst_pkg::ST_IR_SHIFT |=> r.ir == {$past(r.s2.tdi), $past(r.ir[3:1])};
  endproperty
  a_ir_shift_in: assert property (p_ir_shift_in)
    else $error("Instruction shift did not take the serial input.");

  property p_tdo_on_fall;
    !fall |=> $stable(r.tdo);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("Serial output changed off a falling test-clock edge.");

  property p_tms_path;
    rise && r.tap == bst_pkg::ST_IDLE |=>
      (r.tap == ($past(r.s2.tms) ? bst_pkg::ST_DR_SELECT : bst_pkg::ST_IDLE));
  endproperty
  a_tms_path: assert property (p_tms_path)
    else $error("Idle state left against the sampled mode-select.");

  property p_trst_init;
    @(posedge clock) disable iff (1'b0) !trst_n |-> r.tap == bst_pkg::ST_RESET;
  endproperty
  a_trst_init: assert property (p_trst_init)
    else $error("Controller not in reset while test reset is low.");

  property p_oe_shift;
    fall |=> tdo_oe == $past(shifting);
  endproperty
  a_oe_shift: assert property (p_oe_shift)
    else $error("Serial output enable wrong after a falling edge.");

  property p_update_to_idle;
    rise && r.tap == bst_pkg::ST_DR_UPD && !r.s2.tms |=>
      r.tap == bst_pkg::ST_IDLE ##1 r.push == 1'b0;
  endproperty
  a_update_to_idle: assert property (p_update_to_idle)
    else $error("Data update did not return to idle.");

  property p_push_once;
    r.push |=> !r.push;
  endproperty
  a_push_once: assert property (p_push_once)
    else $error("Update pushed more than one word.");

endmodule : bst_tap_port

// ### core/bst_pkg.sv
// Package of constants, state codes and carrier types for the boundary-scan port.
package bst_pkg;

  localparam int unsigned IR_W       = 4;
  localparam int unsigned DR_W       = 8;
  localparam int unsigned FIFO_DEPTH = 4;

  localparam logic [3:0] IR_CAPTURE  = 4'h1;
  localparam logic [3:0] INS_BYPASS  = 4'hF;
  localparam logic [3:0] INS_STREAM  = 4'h2;
  localparam logic [3:0] INS_RESET   = 4'hF;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;

  typedef enum logic [15:0] {
    ST_RESET     = 16'h0001,
    ST_IDLE      = 16'h0002,
    ST_DR_SELECT = 16'h0004,
    ST_DR_CAP    = 16'h0008,
    ST_DR_SHIFT  = 16'h0010,
    ST_DR_EXIT1  = 16'h0020,
    ST_DR_PAUSE  = 16'h0040,
    ST_DR_EXIT2  = 16'h0080,
    ST_DR_UPD    = 16'h0100,
    ST_IR_SELECT = 16'h0200,
    ST_IR_CAP    = 16'h0400,
    ST_IR_SHIFT  = 16'h0800,
    ST_IR_EXIT1  = 16'h1000,
    ST_IR_PAUSE  = 16'h2000,
    ST_IR_EXIT2  = 16'h4000,
    ST_IR_UPD    = 16'h8000
  } bst_tap_t;

  function automatic bst_tap_t bst_next(input bst_tap_t s, input logic tms);
    unique case (s)
      ST_RESET:     bst_next = tms ? ST_RESET     : ST_IDLE;
      ST_IDLE:      bst_next = tms ? ST_DR_SELECT : ST_IDLE;
      ST_DR_SELECT: bst_next = tms ? ST_IR_SELECT : ST_DR_CAP;
      ST_DR_CAP:    bst_next = tms ? ST_DR_EXIT1  : ST_DR_SHIFT;
      ST_DR_SHIFT:  bst_next = tms ? ST_DR_EXIT1  : ST_DR_SHIFT;
      ST_DR_EXIT1:  bst_next = tms ? ST_DR_UPD    : ST_DR_PAUSE;
      ST_DR_PAUSE:  bst_next = tms ? ST_DR_EXIT2  : ST_DR_PAUSE;
      ST_DR_EXIT2:  bst_next = tms ? ST_DR_UPD    : ST_DR_SHIFT;
      ST_DR_UPD:    bst_next = tms ? ST_DR_SELECT : ST_IDLE;
      ST_IR_SELECT: bst_next = tms ? ST_RESET     : ST_IR_CAP;
      ST_IR_CAP:    bst_next = tms ? ST_IR_EXIT1  : ST_IR_SHIFT;
      ST_IR_SHIFT:  bst_next = tms ? ST_IR_EXIT1  : ST_IR_SHIFT;
      ST_IR_EXIT1:  bst_next = tms ? ST_IR_UPD    : ST_IR_PAUSE;
      ST_IR_PAUSE:  bst_next = tms ? ST_IR_EXIT2  : ST_IR_PAUSE;
      ST_IR_EXIT2:  bst_next = tms ? ST_IR_UPD    : ST_IR_SHIFT;
      ST_IR_UPD:    bst_next = tms ? ST_DR_SELECT : ST_IDLE;
      default:      bst_next = ST_RESET;
    endcase
  endfunction : bst_next

endpackage : bst_pkg

// ### sim/bst_ctrl_model.sv
// Test controller model that drives the link pins one test-clock period at a time.
`timescale 1ns/1ns

module bst_ctrl_model (
  input  wire logic clock,  // System clock, paces the link edges.
  output logic      tck,    // Test clock, low between periods.
  output logic      tms,    // Mode select.
  output logic      tdi,    // Serial data to the port.
  input  wire logic tdo,    // Serial data from the port.
  input  wire logic tdo_oe  // Port drives the serial output.
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One 160 ns period: pins set at the fall, 80 ns low, 80 ns high.
  // The serial output is read at the end of the high half, well after the last fall.
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    tms = m;
    tdi = d;
    repeat (4) @(posedge clock);
    #2 tck = 1'b1;
    repeat (4) @(posedge clock);
    #2 q = tdo;
    oe = tdo_oe;
    tck = 1'b0;
  endtask : step
endmodule : bst_ctrl_model

// ### sim/boundary_scan_tap_port_tb_top.sv
// Self-checking bench for the boundary-scan access port.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp=%h got=%h", nm, e, g); end end

module boundary_scan_tap_port_tb_top;
  logic       clock = 1'b0;
  logic       nrst = 1'b1;
  logic       trst_n = 1'b1;
  logic       tck, tms, tdi, tdo, tdo_oe;
  logic [7:0] cap_data = 8'h3C;
  logic       out_valid, drop_seen;
  logic       out_ready = 1'b0;
  logic [7:0] out_data;
  logic [7:0] d;
  logic       oe, q;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  always #10 clock = ~clock;

  bst_ctrl_model i_ctrl (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
                         .tdo_oe(tdo_oe));
  bst_tap_port i_dut (.clock(clock), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
                      .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .cap_data(cap_data),
                      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
                      .drop_seen(drop_seen));

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  // Full scan from idle, optionally through the pause states, back to idle.
  task automatic scan(input logic ir, input logic pz, input logic [7:0] din, input int n);
    int i;
    d = 8'h00;
    oe = 1'b1;
    i_ctrl.step(1'b1, 1'b0, q, oe);
    if (ir) i_ctrl.step(1'b1, 1'b0, q, oe);
    i_ctrl.step(1'b0, 1'b0, q, oe);
    i_ctrl.step(1'b0, 1'b0, q, oe);
    for (i = 0; i < n; i++) begin
      i_ctrl.step(i == n - 1, din[i], q, oe);
      d[i] = q;
      `CHK("tdo_oe_shift", 1'b1, oe)
    end
    if (pz) begin
      i_ctrl.step(1'b0, 1'b0, q, oe);
      `CHK("tdo_oe_pause", 1'b0, oe)
      i_ctrl.step(1'b1, 1'b0, q, oe);
    end
    i_ctrl.step(1'b1, 1'b0, q, oe);
    i_ctrl.step(1'b0, 1'b0, q, oe);
  endtask : scan

  task automatic t_ir;
    `CHK("tdo_oe_reset", 1'b0, tdo_oe)
    `CHK("out_valid_reset", 1'b0, out_valid)
    i_ctrl.step(1'b0, 1'b0, q, oe);
    scan(1'b1, 1'b1, {4'h0, bst_pkg::INS_STREAM}, 4);
    `CHK("ir_capture", bst_pkg::IR_CAPTURE, d[3:0])
  endtask : t_ir

  task automatic t_fill;
    logic [7:0] w;
    for (int k = 0; k < 5; k++) begin
      scan(1'b0, 1'b0, 8'hA0 + k[7:0], 8);
      `CHK("dr_capture", cap_data, d)
      `CHK("drop_seen", k == 4, drop_seen)
    end
    for (int k = 0; k < 4; k++) begin
      w = 8'hA0 + k[7:0];
      `CHK("out_valid", 1'b1, out_valid)
      `CHK("out_data", w, out_data)
      @(posedge clock) #2 out_ready = 1'b1;
      @(posedge clock) #2 out_ready = 1'b0;
    end
    `CHK("out_valid_empty", 1'b0, out_valid)
  endtask : t_fill

  task automatic t_trst;
    scan(1'b0, 1'b0, 8'h5A, 8);
    i_ctrl.step(1'b1, 1'b0, q, oe);
    i_ctrl.step(1'b0, 1'b0, q, oe);
    i_ctrl.step(1'b0, 1'b0, q, oe);
    i_ctrl.step(1'b0, 1'b1, q, oe);
    `CHK("tdo_oe_mid", 1'b1, tdo_oe)
    trst_n = 1'b0;
    #1 `CHK("tdo_oe_trst", 1'b0, tdo_oe)
    `CHK("out_valid_trst", 1'b0, out_valid)
    `CHK("drop_seen_trst", 1'b0, drop_seen)
    @(posedge clock) #2 trst_n = 1'b1;
    repeat (3) @(posedge clock);
    #2 i_ctrl.step(1'b0, 1'b0, q, oe);
    scan(1'b0, 1'b0, 8'h81, 8);
    `CHK("bypass_out", 8'h02, d)
  endtask : t_trst

  // Reset falls after time zero so the asynchronous reset sees a real edge.
  initial begin
    #2 nrst = 1'b0;
    trst_n = 1'b0;
    repeat (3) @(posedge clock);
    #2 nrst = 1'b1;
    trst_n = 1'b1;
    repeat (3) @(posedge clock);
    #2 t_ir();
    t_fill();
    t_trst();
    close_out();
  end
endmodule : boundary_scan_tap_port_tb_top
